// ==== hw/scb_pkg.sv ====
// Package for the slot circuit breaker controller: shared constants and types.
// Assumes a single 10 MHz clock and no software-visible registers.
package scb_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  // Clock rate in kHz.
  localparam int unsigned CLK_KHZ          = 10000;
  // Default filter delay in microseconds.
  localparam int unsigned FILTER_DELAY_US  = 1000;
  // Filter delay in clock cycles, rounded down as a longest time.
  localparam int unsigned FILTER_DELAY_CYC = (FILTER_DELAY_US * CLK_KHZ) / 1000;
  // Width of the filter counters.
  localparam int unsigned FILT_W           = 24;
  // Number of slots served.
  localparam int unsigned NUM_SLOTS        = 2;
  // Number of main rails per slot (12 V and 3.3 V).
  localparam int unsigned NUM_MAIN         = 2;

  // ==========================================================
  // Slot state
  // ==========================================================
  // Main path state.
  typedef enum logic [1:0] {
    SCB_MAIN_OFF     = 2'b00,
    SCB_MAIN_ON      = 2'b01,
    SCB_MAIN_TRIPPED = 2'b10
  } scb_main_e;
endpackage

// ==== hw/scb_filter_if.sv ====
// Interface between the slot controller and the filter delay counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface scb_filter_if;
  // Overcurrent event present.
  logic event_on;
  // Filter delay has expired.
  logic expired;
  // Controller side.
  modport ctrl (output event_on, input expired);
  // Counter side.
  modport cnt  (input event_on, output expired);
endinterface
`default_nettype wire

// ==== hw/scb_filter_counter.sv ====
// Filter delay counter: counts while an overcurrent event stands.
// Assumes the event input is synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module scb_filter_counter #(
  parameter int unsigned DELAY = scb_pkg::FILTER_DELAY_CYC
) (
  input  wire logic   mclk,
  input  wire logic   rst_n,
  scb_filter_if.cnt   filt
);
  import scb_pkg::*;

  // Elapsed count.
  logic [FILT_W-1:0] count_q, count_d;
  // Expiry flag.
  logic              exp_q, exp_d;

  // ==========================================================
  // Counter
  // ==========================================================
  // Counts up while the event stands and clears when it drops.
  always_comb begin
    count_d = '0;
    exp_d   = 1'b0;
    if (filt.event_on) begin // see [RQ16]
      if (count_q >= FILT_W'(DELAY - 1)) begin
        count_d = count_q;
        exp_d   = 1'b1;
      end else begin
        count_d = count_q + 1'b1;
      end
    end
  end

  // Registers the counter state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      exp_q   <= 1'b0;
    end else begin
      count_q <= count_d;
      exp_q   <= exp_d;
    end
  end

  assign filt.expired = exp_q;
endmodule
`default_nettype wire

// ==== hw/scb_slot_breaker.sv ====
// Dual-slot circuit breaker and fault reporting logic.
// Assumes comparator outputs and host enables are synchronous to mclk.
// The host sees only enables, fault pins, power-good, standby and the interrupt; there are no registers.
//
// Notes on behaviour
// [RQ1] Sustained limit overcurrent trips main rails only.
// [RQ2] Fast-trip threshold shuts main outputs immediately.
// [RQ3] Main undervoltage trips only while mains enabled.
// [RQ4] Aux trip after filter; drops aux and mains.
// [RQ5] Host re-arms by toggling the faulted enable.
// [RQ6] Trip raises matching fault and shared interrupt.
// [RQ7] Interrupt clears only on enable falling edge.
// [RQ8] Current regulation during start-up starts filter timer.
// [RQ9] Power-good flag set after threshold, current below limit.
// [RQ10] Switched-off slot outputs get discharge paths.
// [RQ11] Standby whenever a main input is low.
// [RQ12] Aux output follows aux enable, ignores main supply.
// [RQ13] Main undervoltage with enable high reports fault.
// [RQ14] Each slot has its own filter delay.
// [RQ15] Mains enable on enable rise with card retained.
// [RQ16] Filter delay is a clearing cycle counter.
`timescale 1ns/100ps
`default_nettype none
module scb_slot_breaker #(
  parameter int unsigned FILTER_DELAY_A = scb_pkg::FILTER_DELAY_CYC,
  parameter int unsigned FILTER_DELAY_B = scb_pkg::FILTER_DELAY_CYC
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic [scb_pkg::NUM_SLOTS-1:0] main_enable_in,
  input  wire logic [scb_pkg::NUM_SLOTS-1:0] aux_enable_in,
  input  wire logic [scb_pkg::NUM_SLOTS-1:0] card_retained_n,
  input  wire logic [scb_pkg::NUM_SLOTS-1:0] main_12v_uvlo_ok,
  input  wire logic [scb_pkg::NUM_SLOTS-1:0] main_3v_uvlo_ok,
  input  wire logic [scb_pkg::NUM_SLOTS-1:0] standby_supply,
  input  wire logic [3:0]                    limit_threshold,
  input  wire logic [3:0]                    fast_trip_threshold,
  input  wire logic [3:0]                    main_above_pg,
  input  wire logic [scb_pkg::NUM_SLOTS-1:0] aux_over_limit,
  output logic      [3:0]                    main_gate_on,
  output logic      [scb_pkg::NUM_SLOTS-1:0] aux_rail_out,
  output logic      [3:0]                    main_discharge,
  output logic      [scb_pkg::NUM_SLOTS-1:0] aux_discharge,
  output logic      [3:0]                    main_power_good,
  output logic      [scb_pkg::NUM_SLOTS-1:0] fault_main_n,
  output logic      [scb_pkg::NUM_SLOTS-1:0] fault_aux_n,
  output logic                               int_n,
  output logic                               standby_mode
);
  import scb_pkg::*;

  // ==========================================================
  // Edge detection of host enables
  // ==========================================================
  // Previous enable levels for edge detection.
  logic [NUM_SLOTS-1:0] mainEnPrev_q, mainEnPrev_d;
  logic [NUM_SLOTS-1:0] auxEnPrev_q, auxEnPrev_d;
  // Rising and falling edge strobes.
  logic [NUM_SLOTS-1:0] mainRise, mainFall, auxFall;

  // Tracks the enables one cycle back.
  // History resets low, so an enable held high through reset counts as a rise.
  always_comb begin
    mainEnPrev_d = main_enable_in;
    auxEnPrev_d  = aux_enable_in;
  end

  // Registers the enable history.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mainEnPrev_q <= '0;
      auxEnPrev_q  <= '0;
    end else begin
      mainEnPrev_q <= mainEnPrev_d;
      auxEnPrev_q  <= auxEnPrev_d;
    end
  end

  // Strobes last one cycle and are read only by the next-state logic below.
  assign mainRise = main_enable_in & ~mainEnPrev_q;
  assign mainFall = ~main_enable_in & mainEnPrev_q;
  assign auxFall  = ~aux_enable_in & auxEnPrev_q;

  // ==========================================================
  // Standby detection
  // ==========================================================
  // Either main input below its lockout forces standby.
  // The level is shared: one low main input puts the whole device in standby.
  logic [NUM_SLOTS-1:0] mainSupplyOk;
  assign mainSupplyOk = main_12v_uvlo_ok & main_3v_uvlo_ok;

  // ==========================================================
  // Per-slot filter counters
  // ==========================================================
  // Main and aux counters of a slot share its delay, but never its count.
  // Expiry of each main and aux filter counter.
  logic [NUM_SLOTS-1:0] mainFiltExp, auxFiltExp;
  // Event requests into the counters.
  logic [NUM_SLOTS-1:0] mainFiltEvt, auxFiltEvt;

  genvar s;
  generate
    for (s = 0; s < NUM_SLOTS; s++) begin : g_filt
      scb_filter_if mainIf ();
      scb_filter_if auxIf ();
      // Each slot gets its own delay setting.
      localparam int unsigned DLY = (s == 0) ? FILTER_DELAY_A : FILTER_DELAY_B; // see [RQ14]
      assign mainIf.event_on = mainFiltEvt[s];
      assign auxIf.event_on  = auxFiltEvt[s];
      assign mainFiltExp[s]  = mainIf.expired;
      assign auxFiltExp[s]   = auxIf.expired;
      // Main counter: limit overcurrent on either main rail of the slot.
      scb_filter_counter #(.DELAY(DLY)) u_main_filt (
        .mclk  (mclk),
        .rst_n (rst_n),
        .filt  (mainIf.cnt)
      );
      // Aux counter: aux rail held in current regulation.
      scb_filter_counter #(.DELAY(DLY)) u_aux_filt (
        .mclk  (mclk),
        .rst_n (rst_n),
        .filt  (auxIf.cnt)
      );
    end
  endgenerate

  // ==========================================================
  // Slot state machines and flags
  // ==========================================================
  // Main path state per slot.
  scb_main_e [NUM_SLOTS-1:0] mainSt_q, mainSt_d;
  // Aux rail on and latched-off flags.
  logic [NUM_SLOTS-1:0]      auxOn_q, auxOn_d;
  logic [NUM_SLOTS-1:0]      auxTrip_q, auxTrip_d;
  // Fault flags, active high internally.
  logic [NUM_SLOTS-1:0]      fMain_q, fMain_d;
  logic [NUM_SLOTS-1:0]      fAux_q, fAux_d;
  // Shared interrupt pending per slot.
  logic [NUM_SLOTS-1:0]      intPend_q, intPend_d;
  // Power-good flags per main rail.
  logic [3:0]                pg_q, pg_d;
  // Registered outputs.
  logic [3:0]                gate_q, gate_d;
  logic [NUM_SLOTS-1:0]      auxOut_q, auxOut_d;
  logic                      stby_q, stby_d;

  // Next-state logic for both slots.
  // Order matters: clears first, then sequencing, then trips last.
  // The temporaries below are reused on each pass of the slot loop.
  always_comb begin
    logic mainOn, limitAny, fastAny, uvTrip, mainTrip, auxTripNow;
    mainOn     = 1'b0;
    limitAny   = 1'b0;
    fastAny    = 1'b0;
    uvTrip     = 1'b0;
    mainTrip   = 1'b0;
    auxTripNow = 1'b0;
    mainSt_d   = mainSt_q;
    auxOn_d    = auxOn_q;
    auxTrip_d  = auxTrip_q;
    fMain_d    = fMain_q;
    fAux_d     = fAux_q;
    intPend_d  = intPend_q;
    pg_d       = pg_q;
    mainFiltEvt = '0;
    auxFiltEvt  = '0;
    gate_d      = '0;
    stby_d     = ~(&mainSupplyOk); // see [RQ11]
    for (int i = 0; i < NUM_SLOTS; i++) begin
      mainOn   = (mainSt_q[i] == SCB_MAIN_ON);
      limitAny = |limit_threshold[2*i +: 2];
      fastAny  = |fast_trip_threshold[2*i +: 2];
      // Limit current, including start-up regulation, runs the filter.
      mainFiltEvt[i] = mainOn & limitAny; // see [RQ8]
      // Aux regulates into a fault; only the timer ends it.
      auxFiltEvt[i]  = auxOn_q[i] & aux_over_limit[i];
      uvTrip     = mainOn & ~mainSupplyOk[i]; // see [RQ3]
      mainTrip   = mainOn & (mainFiltExp[i] | fastAny | uvTrip); // see [RQ1] see [RQ2]
      auxTripNow = auxOn_q[i] & auxFiltExp[i]; // see [RQ4]

      // Clears happen first so that a same-cycle trip wins.
      if (mainFall[i] || auxFall[i]) begin
        intPend_d[i] = 1'b0; // see [RQ7]
      end
      if (mainFall[i]) begin
        fMain_d[i] = 1'b0;
        if (mainSt_q[i] == SCB_MAIN_TRIPPED) begin
          mainSt_d[i] = SCB_MAIN_OFF; // see [RQ5]
        end
      end
      if (auxFall[i]) begin
        fAux_d[i]    = 1'b0;
        auxTrip_d[i] = 1'b0;
      end

      // Main path sequencing.
      unique case (mainSt_q[i])
        SCB_MAIN_OFF: begin
          // A rise is refused without a retained card, a good supply, or with aux latched.
          if (mainRise[i] && !card_retained_n[i] && mainSupplyOk[i] && !auxTrip_q[i]) begin
            mainSt_d[i] = SCB_MAIN_ON; // see [RQ15]
          end
        end
        SCB_MAIN_ON: begin
          // Dropping the enable or removing the card turns the mains off.
          if (!main_enable_in[i] || card_retained_n[i]) begin
            mainSt_d[i] = SCB_MAIN_OFF;
          end
        end
        SCB_MAIN_TRIPPED: begin
          // Held until the enable falls; the clear above then moves it to off.
        end
        default: begin
          // Unused code: recover to off.
          mainSt_d[i] = SCB_MAIN_OFF;
        end
      endcase

      // Aux rail follows its enable, card, standby supply and trip latch, not the main supply.
      if (auxTrip_q[i] || !aux_enable_in[i] || card_retained_n[i] || !standby_supply[i]) begin
        auxOn_d[i] = 1'b0; // see [RQ12]
      end else begin
        // Level control: aux returns once every blocking condition has gone.
        auxOn_d[i] = 1'b1;
      end

      // Trips override everything above.
      if (mainTrip) begin
        mainSt_d[i]  = SCB_MAIN_TRIPPED;
        fMain_d[i]   = 1'b1; // see [RQ6] see [RQ13]
        intPend_d[i] = 1'b1;
      end
      if (auxTripNow) begin
        auxTrip_d[i] = 1'b1;
        auxOn_d[i]   = 1'b0;
        // Mains go off without a main fault; a new rise is needed to restart.
        mainSt_d[i]  = (mainSt_d[i] == SCB_MAIN_ON) ? SCB_MAIN_OFF : mainSt_d[i];
        fAux_d[i]    = 1'b1; // see [RQ6]
        intPend_d[i] = 1'b1;
      end

      // Power good once above threshold and out of limit.
      for (int r = 0; r < NUM_MAIN; r++) begin
        if (mainSt_d[i] != SCB_MAIN_ON) begin
          pg_d[2*i+r] = 1'b0;
        end else if (main_above_pg[2*i+r] && !limit_threshold[2*i+r]) begin
          pg_d[2*i+r] = 1'b1; // see [RQ9]
        end
      end
    end
    // Both main rails of a slot share one state, so both gates move together.
    for (int i = 0; i < NUM_SLOTS; i++) begin
      gate_d[2*i]   = (mainSt_d[i] == SCB_MAIN_ON);
      gate_d[2*i+1] = (mainSt_d[i] == SCB_MAIN_ON);
    end
    auxOut_d = auxOn_d;
  end

  // Registers slot state and outputs.
  // Reset leaves every rail off and every fault flag clear.
  // Standby reads as set until the supply flags have been sampled.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mainSt_q  <= '{default: SCB_MAIN_OFF};
      auxOn_q   <= '0;
      auxTrip_q <= '0;
      fMain_q   <= '0;
      fAux_q    <= '0;
      intPend_q <= '0;
      pg_q      <= '0;
      gate_q    <= '0;
      auxOut_q  <= '0;
      stby_q    <= 1'b1;
    end else begin
      mainSt_q  <= mainSt_d;
      auxOn_q   <= auxOn_d;
      auxTrip_q <= auxTrip_d;
      fMain_q   <= fMain_d;
      fAux_q    <= fAux_d;
      intPend_q <= intPend_d;
      pg_q      <= pg_d;
      gate_q    <= gate_d;
      auxOut_q  <= auxOut_d;
      stby_q    <= stby_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Off rails get a discharge path.
  // Fault and interrupt pins are active low; the flags are kept active high.
  // The interrupt stands while any slot has a trip not yet acknowledged.
  assign main_gate_on    = gate_q;
  assign main_discharge  = ~gate_q; // see [RQ10]
  assign aux_rail_out    = auxOut_q;
  assign aux_discharge   = ~auxOut_q; // see [RQ10]
  assign main_power_good = pg_q;
  assign fault_main_n    = ~fMain_q;
  assign fault_aux_n     = ~fAux_q;
  assign int_n           = ~(|intPend_q);
  assign standby_mode    = stby_q;
endmodule
`default_nettype wire

// ==== bench/scb_host_model.sv ====
// Host side model that drives the per-slot main and aux enables.
// Assumes the bench changes its requests just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module scb_host_model (
  input  wire logic [1:0] wantMain,
  input  wire logic [1:0] wantAux,
  input  wire logic [1:0] dropMain,
  input  wire logic [1:0] dropAux,
  input  wire logic       goStby,
  output logic      [1:0] mainEn,
  output logic      [1:0] auxEn
);
  // ==========================================================
  // Enables
  // ==========================================================
  // A one-cycle drop gives the high-low-high re-arm toggle.
  // Standby entry lowers both main enables first.
  assign mainEn = wantMain & ~dropMain & {2{~goStby}};
  assign auxEn  = wantAux & ~dropAux;
endmodule
`default_nettype wire

// ==== bench/scb_slot_breaker_properties.sv ====
// Checker for slot 0 of the breaker controller, bound to its top module.
// Assumes the bench runs the filter delay parameters at 5 cycles.
`timescale 1ns/100ps
`default_nettype none
module scb_slot_breaker_properties (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [1:0] main_enable_in,
  input wire logic [1:0] aux_enable_in,
  input wire logic [1:0] card_retained_n,
  input wire logic [1:0] main_12v_uvlo_ok,
  input wire logic [1:0] main_3v_uvlo_ok,
  input wire logic [1:0] standby_supply,
  input wire logic [3:0] limit_threshold,
  input wire logic [3:0] fast_trip_threshold,
  input wire logic [1:0] aux_over_limit,
  input wire logic [3:0] main_gate_on,
  input wire logic [1:0] aux_rail_out,
  input wire logic [3:0] main_discharge,
  input wire logic [1:0] aux_discharge,
  input wire logic [1:0] fault_main_n,
  input wire logic [1:0] fault_aux_n,
  input wire logic       int_n,
  input wire logic       standby_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Trip sequences
  // ==========================================================
  // A main limit overload held on by slot 0 for longer than the filter delay.
  sequence limHeld;
    main_gate_on[0] ##0 (limit_threshold[1:0] != 2'b00) [*8];
  endsequence
  // An aux overload held by slot 0 for longer than the filter delay.
  sequence auxHeld;
    aux_rail_out[0] ##0 aux_over_limit[0] [*8];
  endsequence
  chk_limit_trip: assert property (limHeld |=> main_gate_on[1:0] == 2'b00 && !fault_main_n[0] && aux_rail_out[0] == $past(aux_rail_out[0])) else $error("limit trip wrong");
  chk_fast_trip: assert property (fast_trip_threshold[1:0] != 2'b00 && main_gate_on[0] |=> main_gate_on[1:0] == 2'b00 && !fault_main_n[0] && !int_n) else $error("fast trip late");
  chk_uv_trip: assert property (main_gate_on[0] && !(main_12v_uvlo_ok[0] && main_3v_uvlo_ok[0]) |=> !main_gate_on[0] && !fault_main_n[0]) else $error("brown-out missed");
  chk_off_no_fault: assert property (main_gate_on[1:0] == 2'b00 && fault_main_n[0] |=> fault_main_n[0]) else $error("fault while off");
  chk_aux_trip: assert property (auxHeld |=> !aux_rail_out[0] && !fault_aux_n[0] && main_gate_on[1:0] == 2'b00) else $error("aux trip wrong");
  chk_int_with_fault: assert property ($fell(fault_main_n[0]) || $fell(fault_aux_n[0]) |-> !int_n) else $error("int not with fault");
  chk_int_hold: assert property (!int_n && (($past(main_enable_in) & ~main_enable_in) | ($past(aux_enable_in) & ~aux_enable_in)) == 2'b00 |=> !int_n) else $error("int cleared early");
  chk_discharge_paths: assert property (main_discharge == ~main_gate_on && aux_discharge == ~aux_rail_out) else $error("discharge wrong");
  chk_standby_flag: assert property (1'b1 |=> standby_mode == !(&{$past(main_12v_uvlo_ok), $past(main_3v_uvlo_ok)})) else $error("standby wrong");
  chk_aux_keeps_on: assert property (aux_rail_out[0] && aux_enable_in[0] && !card_retained_n[0] && standby_supply[0] && !aux_over_limit[0] |=> aux_rail_out[0]) else $error("aux dropped");
  chk_main_turn_on: assert property ($rose(main_enable_in[0]) && !card_retained_n[0] && main_12v_uvlo_ok[0] && main_3v_uvlo_ok[0] && fault_main_n[0] && fault_aux_n[0] && fast_trip_threshold[1:0] == 2'b00 |=> main_gate_on[1:0] == 2'b11) else $error("turn-on missed");
endmodule
bind scb_slot_breaker scb_slot_breaker_properties chkI (.mclk, .rst_n, .main_enable_in, .aux_enable_in, .card_retained_n,
  .main_12v_uvlo_ok, .main_3v_uvlo_ok, .standby_supply, .limit_threshold, .fast_trip_threshold, .aux_over_limit,
  .main_gate_on, .aux_rail_out, .main_discharge, .aux_discharge, .fault_main_n, .fault_aux_n, .int_n, .standby_mode);
`default_nettype wire

// ==== bench/scb_slot_breaker_bench.sv ====
// Self-checking bench for the dual-slot breaker controller.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module scb_slot_breaker_bench;
  import scb_pkg::*;
  logic        mclk = 0, rst_n = 0, goStby = 0;
  logic [1:0]  wantMain = 0, wantAux = 0, dropMain = 0, dropAux = 0, mainEn, auxEn;
  logic [1:0]  cardN = 2'b11, uv12 = 2'b11, uv3 = 2'b11, auxLim = 0, vsb = 2'b11, aux, aDis, fM, fA;
  logic [3:0]  lim = 0, fast = 0, pgIn = 0, gate, mDis, pg;
  logic        intN, stby;
  logic [31:0] rnd = 32'h865f57d5;
  int          failures = 0, checked = 0, cyc = 0;
  initial forever #50 mclk = ~mclk;
  scb_host_model host (.wantMain(wantMain), .wantAux(wantAux), .dropMain(dropMain), .dropAux(dropAux),
    .goStby(goStby), .mainEn(mainEn), .auxEn(auxEn));
  scb_slot_breaker #(.FILTER_DELAY_A(5), .FILTER_DELAY_B(5)) DUT (.mclk(mclk), .rst_n(rst_n),
    .main_enable_in(mainEn), .aux_enable_in(auxEn), .card_retained_n(cardN), .main_12v_uvlo_ok(uv12),
    .main_3v_uvlo_ok(uv3), .standby_supply(vsb), .limit_threshold(lim), .fast_trip_threshold(fast),
    .main_above_pg(pgIn), .aux_over_limit(auxLim), .main_gate_on(gate), .aux_rail_out(aux),
    .main_discharge(mDis), .aux_discharge(aDis), .main_power_good(pg), .fault_main_n(fM),
    .fault_aux_n(fA), .int_n(intN), .standby_mode(stby));
  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Main rail pair of slot s, either on or off.
  function automatic logic [3:0] pair(input int s, input logic v);
    return v ? (4'h3 << (2 * s)) : 4'h0;
  endfunction
  // Compares one seen value with its expectation.
  task automatic cmp(input string what, input logic [3:0] seen, input logic [3:0] expv);
    checked++;
    if (seen !== expv) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    tick(6);
    rst_n = 1;
    cmp("reset gate", gate, 4'h0);
    cmp("reset discharge", mDis, 4'hf);
    for (int s = 0; s < 2; s++) begin
      // A rise without a retained card is refused.
      wantMain[s] = 1;
      tick(2);
      cmp("no card gate", gate, 4'h0);
      wantMain[s] = 0;
      cardN[s] = 0;
      wantAux[s] = 1;
      tick(1);
      wantMain[s] = 1;
      tick(3);
      cmp("gate on", gate, pair(s, 1));
      cmp("discharge on", mDis, ~pair(s, 1));
      rnd = lfsr(rnd);
      fast[2 * s + rnd[0]] = 1;
      tick(1);
      fast = 0;
      tick(1);
      cmp("fast gate", gate, 4'h0);
      cmp("fast fault", {2'b0, fM}, {2'b0, ~(2'b1 << s)});
      tick(4);
      cmp("int held", {3'b0, intN}, 4'h0);
      dropMain[s] = 1;
      tick(1);
      dropMain = 0;
      tick(3);
      cmp("rearm int", {3'b0, intN}, 4'h1);
      cmp("rearm gate", gate, pair(s, 1));
      lim[2 * s] = 1;
      tick(4);
      lim = 0;
      tick(1);
      lim[2 * s + 1] = 1;
      cmp("short limit", gate, pair(s, 1));
      tick(10);
      lim = 0;
      cmp("limit gate", gate, 4'h0);
      cmp("limit aux", {3'b0, aux[s]}, 4'h1);
      dropMain[s] = 1;
      tick(1);
      dropMain = 0;
      rnd = lfsr(rnd);
      // The low rail of the slot always crosses; the other is random.
      pgIn = pair(s, 1) & (rnd[3:0] | 4'h5);
      tick(4);
      cmp("power good", pg, pair(s, 1) & (rnd[3:0] | 4'h5));
      pgIn = 0;
      uv12[s] = 0;
      tick(2);
      cmp("uv gate", gate, 4'h0);
      cmp("uv fault", {3'b0, fM[s]}, 4'h0);
      cmp("uv standby", {3'b0, stby}, 4'h1);
      cmp("uv aux", {3'b0, aux[s]}, 4'h1);
      wantMain[s] = 0;
      tick(3);
      cmp("uv off", {3'b0, fM[s]}, 4'h1);
      uv12[s] = 1;
      wantMain[s] = 1;
      tick(2);
      auxLim[s] = 1;
      tick(10);
      auxLim = 0;
      cmp("aux trip", {2'b0, aux[s], fA[s]}, 4'h0);
      cmp("aux mains", {gate[2 * s +: 2], fM[s], intN}, 4'h2);
      dropAux[s] = 1;
      tick(1);
      dropAux = 0;
      tick(3);
      cmp("aux rearm", {1'b0, aux[s], fA[s], intN}, 4'h7);
      // Losing the standby supply drops aux; its return brings aux back.
      vsb[s] = 0;
      tick(2);
      cmp("standby supply off", {2'b0, aux[s], aDis[s]}, 4'h1);
      vsb[s] = 1;
      tick(2);
      cmp("standby supply back", {2'b0, aux[s], aDis[s]}, 4'h2);
      wantMain[s] = 0;
      tick(2);
    end
    wantMain = 2'b11;
    tick(3);
    goStby = 1;
    tick(2);
    uv3 = 2'b00;
    tick(3);
    cmp("standby faults", {stby, 1'b0, fM}, 4'hb);
    stop_test();
  end
endmodule
`default_nettype wire
